// File: smc_pkg.sv
// Constants and types for source-match auto_pending_flag control
package smc_pkg;

    localparam int SHORT_ENTRIES = 24;
    localparam int LONG_ENTRIES  = 12;
    localparam int MASK_W        = 24;
    localparam int BYTE_W        = 8;
    localparam int SHORT_ADDR_W  = 16;
    localparam int LONG_ADDR_W   = 64;
    localparam int LONG_PER_BYTE = 4;

    // Register indices; byte address is four times the index
    localparam logic [29:0] IDX_FILTER_CTRL = 30'h0000_6180;
    localparam logic [29:0] IDX_MATCH_CTRL  = 30'h0000_6182;
    localparam logic [29:0] IDX_SHORT_EN0   = 30'h0000_6183;
    localparam logic [29:0] IDX_SHORT_EN1   = 30'h0000_6184;
    localparam logic [29:0] IDX_SHORT_EN2   = 30'h0000_6185;
    localparam logic [29:0] IDX_LONG_EN0    = 30'h0000_6186;
    localparam logic [29:0] IDX_LONG_EN1    = 30'h0000_6187;
    localparam logic [29:0] IDX_LONG_EN2    = 30'h0000_6188;
    localparam logic [1:0]  WORD_ALIGN      = 2'h0;

    localparam int BIT_FILTER_ON  = 0;
    localparam int BIT_MATCH_EN   = 0;
    localparam int BIT_AUTO_PENDING_FLAG   = 1;
    localparam int BIT_DREQ_ONLY  = 2;

    localparam logic        FILTER_ON_RESET = 1'h1;
    localparam logic [2:0]  CTRL_RESET      = 3'h7;
    localparam logic [23:0] SHORT_EN_RESET  = 24'h00_0000;
    localparam logic [11:0] LONG_EN_RESET   = 12'h000;

    localparam logic [2:0] FTYPE_MAC_CMD    = 3'h3;
    localparam logic [7:0] CMD_DATA_REQUEST = 8'h04;
    localparam logic [1:0] ADDR_MODE_SHORT  = 2'h2;
    localparam logic [1:0] ADDR_MODE_LONG   = 2'h3;

    typedef enum logic [0:0] {SMC_IDLE, SMC_EVAL} smc_phase_t;

    typedef struct packed {
        logic       dreq_only;
        logic       auto_pending_flag;
        logic       match_en;
    } smc_ctrl_t;

    typedef struct packed {
        logic [2:0]  ftype;
        logic [7:0]  cmd_id;
        logic [1:0]  addr_mode;
        logic [63:0] src_addr;
    } smc_frame_t;

    typedef struct packed {
        logic        filt_on;
        smc_ctrl_t   ctrl;
        logic [23:0] short_en;
        logic [11:0] long_en;
        smc_phase_t  phase;
        smc_frame_t  frame;
        logic        pend;
        logic        done;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } smc_state_t;

endpackage

// File: smc_auto_pending_flag.sv
// Source-match enables and automatic ack pending bit, APB slave
//
// Notes on behaviour
// RULE_01: Data-request-only mode also needs data request command.
// RULE_02: Pending set only with filter, match, auto_pending_flag enabled.
// RULE_03: Needs hit enabled in entry and pend mask.
// RULE_04: Match enable ignored while filtering is off.
// RULE_05: Short enables: 24 bits, one per entry.
// RULE_06: Long enables: 24-bit word for 12 entries.
// RULE_07: Long write takes entry n from bit 2n.
// RULE_08: Long read shows entry n on 2n, 2n+1.
// RULE_09: Software clears entry enable while updating entry.
// RULE_10: Software writes zero to control reserved bits.
// RULE_11: Control bits reset to one, enables to zero.
// RULE_12: Each mask split across three consecutive byte registers.
// RULE_13: Filtering active only while filtering_on; resets one.
// RULE_14: Compare source with enabled entries of matching type.
`timescale 1ns/100ps
`default_nettype none

module smc_auto_pending_flag (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 frame_valid,
    input  wire smc_pkg::smc_frame_t  frame_in,
    input  wire logic [23:0][15:0]    short_table,
    input  wire logic [11:0][63:0]    long_table,
    input  wire logic [23:0]          short_pend_mask,
    input  wire logic [11:0]          long_pend_mask,
    output logic                      ack_pending,
    output logic                      pend_valid,
    output logic                      filtering_on
);

    smc_pkg::smc_state_t s;
    smc_pkg::smc_state_t next_s;

    // Word-aligned register select
    function automatic logic reg_hit(
        input logic [31:0] addr,
        input logic [29:0] idx
    );
        reg_hit = (addr[31:2] == idx) && (addr[1:0] == smc_pkg::WORD_ALIGN);
    endfunction

    // Each stored long enable shows on a bit pair
    function automatic logic [7:0] long_read_byte(
        input logic [11:0] en,
        input int          k
    );
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < smc_pkg::LONG_PER_BYTE; i++) begin
            r[2*i]   = en[k*smc_pkg::LONG_PER_BYTE+i];
            r[2*i+1] = en[k*smc_pkg::LONG_PER_BYTE+i];
        end
        return r;
    endfunction

    // Odd bits of a long write are dropped
    function automatic logic [3:0] long_write_byte(
        input logic [7:0] d
    );
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < smc_pkg::LONG_PER_BYTE; i++) begin
            r[i] = d[2*i];
        end
        return r;
    endfunction

    logic setup_phase;
    logic wr_access;
    logic short_hit;
    logic long_hit;
    logic any_hit;
    logic dreq_frame;
    logic gates_on;
    logic eval_pend;
    logic [3:0] long_wr_nib;

    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && s.pready && pwrite && pstrb[0];
    assign long_wr_nib = long_write_byte(pwdata[7:0]);

    // Entry compare runs on the captured frame
    always_comb begin
        short_hit = 1'b0;
        long_hit  = 1'b0;
        for (int i = 0; i < smc_pkg::SHORT_ENTRIES; i++) begin
            if (s.short_en[i] && short_pend_mask[i]
                && (s.frame.addr_mode == smc_pkg::ADDR_MODE_SHORT)
                && (short_table[i] == s.frame.src_addr[15:0])) begin // [RULE_03] [RULE_14]
                short_hit = 1'b1;
            end
        end
        for (int j = 0; j < smc_pkg::LONG_ENTRIES; j++) begin
            if (s.long_en[j] && long_pend_mask[j]
                && (s.frame.addr_mode == smc_pkg::ADDR_MODE_LONG)
                && (long_table[j] == s.frame.src_addr)) begin // [RULE_03] [RULE_14]
                long_hit = 1'b1;
            end
        end
    end

    assign any_hit    = short_hit || long_hit;
    assign dreq_frame = (s.frame.ftype == smc_pkg::FTYPE_MAC_CMD)
                        && (s.frame.cmd_id == smc_pkg::CMD_DATA_REQUEST); // [RULE_01]
    // Filter bit gates match enable, so match enable is moot when off
    assign gates_on   = s.filt_on && s.ctrl.match_en && s.ctrl.auto_pending_flag; // [RULE_02] [RULE_04] [RULE_13]
    assign eval_pend  = gates_on && any_hit
                        && (!s.ctrl.dreq_only || dreq_frame); // [RULE_01] [RULE_02] [RULE_03]

    always_comb begin
        next_s         = s;
        next_s.done    = 1'b0;
        next_s.pready  = 1'b0;

        // Read data and error latched in setup; zero-wait access follows
        if (setup_phase) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = '0;
            if (reg_hit(paddr, smc_pkg::IDX_FILTER_CTRL)) begin
                next_s.prdata[smc_pkg::BIT_FILTER_ON] = s.filt_on;
            end else if (reg_hit(paddr, smc_pkg::IDX_MATCH_CTRL)) begin
                // Reserved bits read back as zero
                next_s.prdata[2:0] = s.ctrl; // [RULE_10]
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN0)) begin
                next_s.prdata[7:0] = s.short_en[7:0]; // [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN1)) begin
                next_s.prdata[7:0] = s.short_en[15:8]; // [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN2)) begin
                next_s.prdata[7:0] = s.short_en[23:16]; // [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN0)) begin
                next_s.prdata[7:0] = long_read_byte(s.long_en, 0); // [RULE_08]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN1)) begin
                next_s.prdata[7:0] = long_read_byte(s.long_en, 1); // [RULE_08]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN2)) begin
                next_s.prdata[7:0] = long_read_byte(s.long_en, 2); // [RULE_08]
            end else begin
                next_s.pslverr = 1'b1;
            end
        end

        // Writes land only at the access edge
        if (wr_access) begin
            if (reg_hit(paddr, smc_pkg::IDX_FILTER_CTRL)) begin
                next_s.filt_on = pwdata[smc_pkg::BIT_FILTER_ON]; // [RULE_13]
            end else if (reg_hit(paddr, smc_pkg::IDX_MATCH_CTRL)) begin
                next_s.ctrl.match_en  = pwdata[smc_pkg::BIT_MATCH_EN];
                next_s.ctrl.auto_pending_flag  = pwdata[smc_pkg::BIT_AUTO_PENDING_FLAG];
                next_s.ctrl.dreq_only = pwdata[smc_pkg::BIT_DREQ_ONLY];
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN0)) begin
                next_s.short_en[7:0] = pwdata[7:0]; // [RULE_05] [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN1)) begin
                next_s.short_en[15:8] = pwdata[7:0]; // [RULE_05] [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_SHORT_EN2)) begin
                next_s.short_en[23:16] = pwdata[7:0]; // [RULE_05] [RULE_12]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN0)) begin
                next_s.long_en[3:0] = long_wr_nib; // [RULE_06] [RULE_07]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN1)) begin
                next_s.long_en[7:4] = long_wr_nib; // [RULE_06] [RULE_07]
            end else if (reg_hit(paddr, smc_pkg::IDX_LONG_EN2)) begin
                next_s.long_en[11:8] = long_wr_nib; // [RULE_06] [RULE_07]
            end
        end

        // Table entries are read live; software disables an entry
        // while it rewrites it, so no half entry can hit
        unique case (s.phase)
            smc_pkg::SMC_IDLE: begin
                if (frame_valid) begin
                    next_s.frame = frame_in;
                    next_s.phase = smc_pkg::SMC_EVAL;
                end
            end
            smc_pkg::SMC_EVAL: begin
                next_s.pend  = eval_pend; // [RULE_02] [RULE_09]
                next_s.done  = 1'b1;
                next_s.phase = smc_pkg::SMC_IDLE;
                // A frame in this cycle is still taken
                if (frame_valid) begin
                    next_s.frame = frame_in;
                    next_s.phase = smc_pkg::SMC_EVAL;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.filt_on  <= smc_pkg::FILTER_ON_RESET; // [RULE_11] [RULE_13]
            s.ctrl     <= smc_pkg::CTRL_RESET; // [RULE_11]
            s.short_en <= smc_pkg::SHORT_EN_RESET; // [RULE_11]
            s.long_en  <= smc_pkg::LONG_EN_RESET; // [RULE_11]
            s.phase    <= smc_pkg::SMC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata       = s.prdata;
    assign pready       = s.pready;
    assign pslverr      = s.pslverr;
    assign ack_pending  = s.pend;
    assign pend_valid   = s.done;
    assign filtering_on = s.filt_on;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    sequence s_read;
        s_setup ##1 (s_access and !pwrite);
    endsequence

    sequence s_frame_seen;
        frame_valid;
    endsequence

    a_result_timing: assert property (s_frame_seen |-> ##2 pend_valid) // [RULE_02]
        else $error("pending result not produced two cycles after frame");

    a_pend_all_gates: assert property (pend_valid && ack_pending |-> $past(gates_on)) // [RULE_02]
        else $error("pending bit set without all enables");

    a_filter_off_quiet: assert property (pend_valid && !$past(s.filt_on) |-> !ack_pending) // [RULE_04]
        else $error("pending bit set while filtering off");

    a_dreq_only_cmd: assert property (
        pend_valid && ack_pending && $past(s.ctrl.dreq_only) |-> $past(dreq_frame)) // [RULE_01]
        else $error("pending bit set for non data request frame");

    a_pend_needs_hit: assert property (pend_valid && ack_pending |-> $past(any_hit)) // [RULE_03]
        else $error("pending bit set without table hit");

    a_hit_sets_pend: assert property (
        s.phase == smc_pkg::SMC_EVAL && eval_pend |=> pend_valid && ack_pending) // [RULE_14]
        else $error("enabled matching entry did not set pending");

    a_long_read_pair: assert property (
        s_read ##0 reg_hit(paddr, smc_pkg::IDX_LONG_EN0)
        |-> prdata[0] == prdata[1] && prdata[6] == prdata[7]) // [RULE_08]
        else $error("long enable read bits not paired");

    a_long_write_even: assert property (
        wr_access && reg_hit(paddr, smc_pkg::IDX_LONG_EN1)
        |=> s.long_en[7:4] == {$past(pwdata[6]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[0])}) // [RULE_07]
        else $error("long enable write not from even bits");

    a_short_write_mid: assert property (
        wr_access && reg_hit(paddr, smc_pkg::IDX_SHORT_EN1)
        |=> s.short_en[15:8] == $past(pwdata[7:0])) // [RULE_12]
        else $error("short enable mid byte not written");

    a_apb_zero_wait: assert property (s_setup |=> pready ##1 !pready) // [RULE_12]
        else $error("access phase not exactly one cycle");

    a_unmapped_error: assert property (
        s_setup ##0 (paddr[1:0] != smc_pkg::WORD_ALIGN) |=> pslverr) // [RULE_12]
        else $error("misaligned access not refused");

    // Reset values seen on the first enabled edge
    a_reset_values: assert property ( // [RULE_11] [RULE_13]
        $rose(presetn) |-> s.filt_on == smc_pkg::FILTER_ON_RESET && s.ctrl == smc_pkg::CTRL_RESET
        && s.short_en == smc_pkg::SHORT_EN_RESET && s.long_en == smc_pkg::LONG_EN_RESET)
        else $error("register state not at reset values after reset");

    a_ctrl_read_resv: assert property ( // [RULE_10]
        s_read ##0 reg_hit(paddr, smc_pkg::IDX_MATCH_CTRL) |-> prdata[31:3] == 29'h0000_0000)
        else $error("reserved control bits not read as zero");

    a_short_write_low: assert property ( // [RULE_05]
        wr_access && reg_hit(paddr, smc_pkg::IDX_SHORT_EN0) |=> s.short_en[7:0] == $past(pwdata[7:0]))
        else $error("short enable low byte not written");

    a_short_write_high: assert property ( // [RULE_05]
        wr_access && reg_hit(paddr, smc_pkg::IDX_SHORT_EN2) |=> s.short_en[23:16] == $past(pwdata[7:0]))
        else $error("short enable high byte not written");

    a_long_write_low: assert property ( // [RULE_07]
        wr_access && reg_hit(paddr, smc_pkg::IDX_LONG_EN0)
        |=> s.long_en[3:0] == {$past(pwdata[6]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[0])})
        else $error("long enable low write not from even bits");

    a_long_write_high: assert property ( // [RULE_07]
        wr_access && reg_hit(paddr, smc_pkg::IDX_LONG_EN2)
        |=> s.long_en[11:8] == {$past(pwdata[6]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[0])})
        else $error("long enable high write not from even bits");

    a_ctrl_write: assert property ( // [RULE_02]
        wr_access && reg_hit(paddr, smc_pkg::IDX_MATCH_CTRL) |=> s.ctrl == $past(pwdata[2:0]))
        else $error("match control bits not written");

    a_filter_write: assert property ( // [RULE_13]
        wr_access && reg_hit(paddr, smc_pkg::IDX_FILTER_CTRL) |=> filtering_on == $past(pwdata[0]))
        else $error("filter enable not written");

    a_short_read_high: assert property ( // [RULE_12]
        s_read ##0 reg_hit(paddr, smc_pkg::IDX_SHORT_EN2) |-> prdata[7:0] == s.short_en[23:16])
        else $error("short enable high byte read wrong");

    a_long_read_mid: assert property ( // [RULE_08]
        s_read ##0 reg_hit(paddr, smc_pkg::IDX_LONG_EN1)
        |-> prdata[7:0] == {{2{s.long_en[7]}}, {2{s.long_en[6]}}, {2{s.long_en[5]}}, {2{s.long_en[4]}}})
        else $error("long enable mid read not paired");

    a_long_read_high: assert property ( // [RULE_08]
        s_read ##0 reg_hit(paddr, smc_pkg::IDX_LONG_EN2)
        |-> prdata[7:0] == {{2{s.long_en[11]}}, {2{s.long_en[10]}}, {2{s.long_en[9]}}, {2{s.long_en[8]}}})
        else $error("long enable high read not paired");

    a_result_source: assert property (pend_valid |-> $past(frame_valid, 2)) // [RULE_02]
        else $error("pending result without a frame two cycles earlier");

    a_result_hold: assert property (!pend_valid |-> $stable(ack_pending)) // [RULE_02]
        else $error("pending bit changed without result strobe");

    a_dreq_needed: assert property ( // [RULE_01]
        s.phase == smc_pkg::SMC_EVAL && s.ctrl.dreq_only && !dreq_frame |=> pend_valid && !ack_pending)
        else $error("pending set for non data request in request-only mode");

    a_miss_no_pend: assert property ( // [RULE_03]
        s.phase == smc_pkg::SMC_EVAL && !any_hit |=> pend_valid && !ack_pending)
        else $error("pending set without enabled pending entry");

    a_match_off: assert property ( // [RULE_02]
        s.phase == smc_pkg::SMC_EVAL && !s.ctrl.match_en |=> pend_valid && !ack_pending)
        else $error("pending set while matching disabled");

endmodule // smc_auto_pending_flag

`default_nettype wire

// File: tb.sv
// Self-checking testbench for the source-match auto_pending_flag control block
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [31:0]         paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                frame_valid;
    smc_pkg::smc_frame_t frame_in;
    logic [23:0][15:0]   short_table;
    logic [11:0][63:0]   long_table;
    logic [23:0]         short_pend_mask;
    logic [11:0]         long_pend_mask;
    logic                ack_pending;
    logic                pend_valid;
    logic                filtering_on;
    int                  n_mismatch;
    int                  samples_checked;
    int                  cycles;

    smc_auto_pending_flag dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .frame_in(frame_in), .short_table(short_table), .long_table(long_table),
        .short_pend_mask(short_pend_mask), .long_pend_mask(long_pend_mask), .ack_pending(ack_pending),
        .pend_valid(pend_valid), .filtering_on(filtering_on));

    always begin
        #25 pclk = ~pclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Values are read before the edge's own updates land, i.e. as sampled
    task automatic apb(input logic wr_en, input logic [31:0] addr, input logic [7:0] d, input logic [3:0] strb,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= addr;
        pwdata  <= {24'h00_0000, d};
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [29:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, {idx, 2'h0}, d, 4'hF, r, e);
    endtask

    task automatic rdchk(input string what, input logic [29:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, {idx, 2'h0}, 8'h00, 4'hF, r, e);
        chk(what, exp, r);
        chk({what, " slave error"}, 32'h0000_0000, {31'h0000_0000, e});
    endtask

    // Tables are held steady through the evaluation cycle
    task automatic fr(input string what, input logic [2:0] ft, input logic [7:0] cmd, input logic [1:0] mode,
                      input logic [63:0] src, input logic exp);
        int n;
        @(posedge pclk);
        frame_valid <= 1'b1;
        frame_in    <= '{ftype: ft, cmd_id: cmd, addr_mode: mode, src_addr: src};
        @(posedge pclk);
        frame_valid <= 1'b0;
        n = 0;
        while (pend_valid !== 1'b1 && n < 6) begin
            @(posedge pclk);
            n++;
        end
        chk({what, " result strobe"}, 32'h0000_0001, {31'h0000_0000, pend_valid});
        chk(what, {31'h0000_0000, exp}, {31'h0000_0000, ack_pending});
    endtask

    task automatic t_reset();
        chk("filtering_on pin", 32'h0000_0001, {31'h0000_0000, filtering_on});
        rdchk("filter control", smc_pkg::IDX_FILTER_CTRL, 32'h0000_0001);
        rdchk("match control", smc_pkg::IDX_MATCH_CTRL, 32'h0000_0007);
        for (int i = 0; i < 6; i++) begin
            rdchk("enable byte", smc_pkg::IDX_SHORT_EN0 + 30'(i), 32'h0000_0000);
        end
    endtask

    task automatic t_short();
        wr(smc_pkg::IDX_SHORT_EN0, 8'hA5);
        wr(smc_pkg::IDX_SHORT_EN1, 8'h5A);
        wr(smc_pkg::IDX_SHORT_EN2, 8'hC3);
        rdchk("short enable low", smc_pkg::IDX_SHORT_EN0, 32'h0000_00A5);
        rdchk("short enable mid", smc_pkg::IDX_SHORT_EN1, 32'h0000_005A);
        rdchk("short enable high", smc_pkg::IDX_SHORT_EN2, 32'h0000_00C3);
    endtask

    task automatic t_long();
        wr(smc_pkg::IDX_LONG_EN0, 8'hAA);
        rdchk("long enable odd bits only", smc_pkg::IDX_LONG_EN0, 32'h0000_0000);
        wr(smc_pkg::IDX_LONG_EN0, 8'h55);
        rdchk("long enable all low", smc_pkg::IDX_LONG_EN0, 32'h0000_00FF);
        wr(smc_pkg::IDX_LONG_EN1, 8'h41);
        rdchk("long enable mid", smc_pkg::IDX_LONG_EN1, 32'h0000_00C3);
        wr(smc_pkg::IDX_LONG_EN2, 8'h04);
        rdchk("long enable high", smc_pkg::IDX_LONG_EN2, 32'h0000_000C);
        wr(smc_pkg::IDX_LONG_EN0, 8'h00);
    endtask

    task automatic t_refuse();
        logic [31:0] r;
        logic        e;
        apb(1'b0, {30'h0000_6181, 2'h0}, 8'h00, 4'hF, r, e);
        chk("unmapped read error", 32'h0000_0001, {31'h0000_0000, e});
        chk("unmapped read data", 32'h0000_0000, r);
        apb(1'b1, {smc_pkg::IDX_SHORT_EN0, 2'h1}, 8'h00, 4'hF, r, e);
        chk("misaligned write error", 32'h0000_0001, {31'h0000_0000, e});
        apb(1'b1, {smc_pkg::IDX_SHORT_EN0, 2'h0}, 8'h00, 4'h0, r, e);
        rdchk("write without strobe", smc_pkg::IDX_SHORT_EN0, 32'h0000_00A5);
    endtask

    task automatic t_frames();
        short_table[5]  <= 16'hBEEF;
        short_pend_mask <= 24'h00_0020;
        long_table[9]   <= 64'h0123_4567_89AB_CDEF;
        long_pend_mask  <= 12'h200;
        fr("short data request", 3'h3, 8'h04, 2'h2, 64'h0000_0000_0000_BEEF, 1'b1);
        fr("other command", 3'h3, 8'h05, 2'h2, 64'h0000_0000_0000_BEEF, 1'b0);
        fr("data frame", 3'h1, 8'h04, 2'h2, 64'h0000_0000_0000_BEEF, 1'b0);
        fr("long data request", 3'h3, 8'h04, 2'h3, 64'h0123_4567_89AB_CDEF, 1'b1);
        fr("wrong address mode", 3'h3, 8'h04, 2'h3, 64'h0000_0000_0000_BEEF, 1'b0);
        fr("no table hit", 3'h3, 8'h04, 2'h2, 64'h0000_0000_0000_BEEE, 1'b0);
        wr(smc_pkg::IDX_MATCH_CTRL, 8'h03);
        fr("any frame type", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_BEEF, 1'b1);
        wr(smc_pkg::IDX_MATCH_CTRL, 8'h01);
        fr("auto_pending_flag off", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_BEEF, 1'b0);
        wr(smc_pkg::IDX_MATCH_CTRL, 8'h02);
        fr("matching off", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_BEEF, 1'b0);
        wr(smc_pkg::IDX_MATCH_CTRL, 8'h03);
        short_pend_mask <= 24'h00_0000;
        fr("entry not pending", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_BEEF, 1'b0);
        short_pend_mask <= 24'h00_0020;
        wr(smc_pkg::IDX_SHORT_EN0, 8'h85);
        short_table[5] <= 16'hCAFE;
        fr("entry held off", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_CAFE, 1'b0);
        wr(smc_pkg::IDX_SHORT_EN0, 8'hA5);
        fr("entry back on", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_CAFE, 1'b1);
        wr(smc_pkg::IDX_FILTER_CTRL, 8'h00);
        // Write lands at the access edge; look one edge later
        @(posedge pclk);
        chk("filtering_on cleared", 32'h0000_0000, {31'h0000_0000, filtering_on});
        fr("filter off", 3'h1, 8'h00, 2'h2, 64'h0000_0000_0000_CAFE, 1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        frame_valid = 1'b0;
        frame_in = '0;
        short_table = '0;
        long_table = '0;
        short_pend_mask = 24'h00_0000;
        long_pend_mask = 12'h000;
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_short();
        t_long();
        t_refuse();
        t_frames();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
